// ==== hdl/wdg_guard.v ====
// timeout guard with reset cause register and bandgap enable
// Operation
// - timeout reset sets flag; power-up or zero-write clears
// - low supply reset sets flag, same clears
// - pin reset sets flag, same clears
// - power-up sets flag; only zero-write clears
// - bandgap on when detector or comparator select
// - counter advances on separate oscillator ticks
// - restart clears counter; expiry acts
// - interrupt mode raises wakeable irq on expiry
// - reset mode asserts system reset on expiry
// - combined mode: irq first, then reset mode
// - always-on fuse forces reset mode
// - protected change only within four cycles
// - timeouts selectable from 16ms to 8s
// - after timeout reset guard stays enabled
// - reset-enable held while timeout flag set
// - unlock bit self-clears after four cycles
// - prescale codes 0..9 double from 2048
// - vector ack clears irq flag; irq enable too only when reset is enabled
//
// Implementation choices: the register addresses and the strobed register port.
`timescale 1ns/1ns
`include "wdg_defs.vh"
module wdg_guard #(
  parameter OSC_DIV = `WDG_CLK_KHZ / `WDG_OSC_KHZ,
  parameter BASE_CYCLES = `WDG_BASE_CYCLES
) (
  // clock and reset
  input wire clk,
  input wire nrst,
  // reset sources, sampled on clock
  input wire power_up_reset,
  input wire pin_reset,
  input wire low_supply_reset,
  // fuses and core events
  input wire guard_always_on_fuse,
  input wire [2:0] low_supply_level_fuse,
  input wire guard_restart,
  input wire guard_vector_taken,
  // register port
  input wire [3:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_write,
  input wire reg_read,
  output reg [7:0] reg_rdata,
  // outputs
  output reg guard_irq,
  output reg guard_system_reset,
  output reg bandgap_enable
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  reg [3:0] cause;
  reg guard_irq_flag;
  reg guard_irq_enable;
  reg guard_reset_enable;
  reg [3:0] guard_prescale_select;
  reg guard_change_unlock;
  reg [2:0] unlock_cnt;
  reg comparator_bandgap_select;
  reg [20:0] tmo_cnt;
  reg running_d;
  wire osc_tick;
  wire wr_cause = reg_write && reg_addr == `WDG_ADDR_CAUSE;
  wire wr_ctrl = reg_write && reg_addr == `WDG_ADDR_CTRL;
  wire wr_misc = reg_write && reg_addr == `WDG_ADDR_MISC;
  wire any_reset = power_up_reset | pin_reset | low_supply_reset;

  // timeout length in oscillator cycles for a prescale code
  function [20:0] tmo_limit;
    input [3:0] code;
    reg [3:0] c;
    begin
      c = (code > `WDG_MAX_CODE) ? `WDG_MAX_CODE : code;
      tmo_limit = BASE_CYCLES[20:0] << c;
    end
  endfunction

  // ----------------------------------------------------------------
  // oscillator
  // ----------------------------------------------------------------
  wdg_tick_gen #(.DIV(OSC_DIV)) u_tick (
    .clk(clk),
    .nrst(nrst),
    .tick(osc_tick)
  );

  // ----------------------------------------------------------------
  // mode and expiry
  // ----------------------------------------------------------------
  wire eff_reset_en = guard_always_on_fuse | guard_reset_enable;
  wire eff_irq_en = guard_irq_enable & ~guard_always_on_fuse;
  wire running = eff_reset_en | eff_irq_en;
  wire expire = running && osc_tick && (tmo_cnt + 21'h000001 >= tmo_limit(guard_prescale_select));
  wire irq_expire = expire && eff_irq_en;
  wire rst_expire = expire && eff_reset_en && !eff_irq_en;
  wire unlock_req = wr_ctrl && reg_wdata[`WDG_UNLOCK_BIT] && reg_wdata[`WDG_RESET_EN_BIT];
  wire unlock_open = guard_change_unlock && !reg_wdata[`WDG_UNLOCK_BIT];
  wire vec_ack = guard_vector_taken || (wr_misc && reg_wdata[`WDG_VECTOR_ACK_BIT]);

  // ----------------------------------------------------------------
  // timeout counter
  // ----------------------------------------------------------------
  reg [20:0] next_tmo_cnt;

  // restart, reset events, expiry and start all begin a fresh count
  always @* begin
    next_tmo_cnt = tmo_cnt;
    if (any_reset || guard_restart || rst_expire || (running && !running_d)) begin
      next_tmo_cnt = 21'h000000;
    end else if (expire) begin
      next_tmo_cnt = 21'h000000;
    end else if (running && osc_tick) begin
      next_tmo_cnt = tmo_cnt + 21'h000001;
    end
  end

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      tmo_cnt <= 21'h000000;
      running_d <= 1'b0;
    end else begin
      tmo_cnt <= next_tmo_cnt;
      running_d <= running;
    end
  end

  // ----------------------------------------------------------------
  // reset cause register
  // ----------------------------------------------------------------
  reg [3:0] next_cause;

  // zero-write first, so an event in the same cycle still sets its flag
  always @* begin
    next_cause = cause;
    if (wr_cause) begin
      next_cause = cause & reg_wdata[3:0];
    end
    if (power_up_reset) begin
      next_cause[`WDG_TIMEOUT_BIT] = 1'b0;
      next_cause[`WDG_LOW_SUPPLY_BIT] = 1'b0;
      next_cause[`WDG_PIN_BIT] = 1'b0;
      next_cause[`WDG_POWER_UP_BIT] = 1'b1;
    end else begin
      if (rst_expire) begin
        next_cause[`WDG_TIMEOUT_BIT] = 1'b1;
      end
      if (low_supply_reset) begin
        next_cause[`WDG_LOW_SUPPLY_BIT] = 1'b1;
      end
      if (pin_reset) begin
        next_cause[`WDG_PIN_BIT] = 1'b1;
      end
    end
  end

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cause <= 4'h0;
    end else begin
      cause <= next_cause;
    end
  end

  // ----------------------------------------------------------------
  // control register
  // ----------------------------------------------------------------
  reg next_irq_flag;
  reg next_irq_enable;
  reg next_reset_enable;
  reg [3:0] next_prescale;
  reg next_unlock;
  reg [2:0] next_unlock_cnt;
  reg next_bandgap_sel;

  // prescale code gathered from its split field
  function [3:0] pre_field;
    input [7:0] d;
    begin
      pre_field = {d[`WDG_PRE3_BIT], d[`WDG_PRE2_BIT], d[`WDG_PRE1_BIT], d[`WDG_PRE0_BIT]};
    end
  endfunction

  // later assignments win: expiry sets the flag over a write or vector clear
  always @* begin
    next_irq_flag = guard_irq_flag;
    next_irq_enable = guard_irq_enable;
    next_reset_enable = guard_reset_enable;
    next_prescale = guard_prescale_select;
    next_unlock = guard_change_unlock;
    next_unlock_cnt = unlock_cnt;
    next_bandgap_sel = comparator_bandgap_select;
    if (wr_misc) begin
      next_bandgap_sel = reg_wdata[`WDG_BANDGAP_SEL_BIT];
    end
    if (any_reset) begin
      // other fields except bandgap select back to initial values; reset-enable kept by flag
      next_irq_flag = 1'b0;
      next_irq_enable = 1'b0;
      next_unlock = 1'b0;
      next_unlock_cnt = 3'h0;
      next_prescale = 4'h0;
      next_reset_enable = cause[`WDG_TIMEOUT_BIT] & ~power_up_reset;
    end else begin
      if (wr_ctrl) begin
        next_irq_enable = reg_wdata[`WDG_IRQ_EN_BIT];
        if (reg_wdata[`WDG_IRQ_FLAG_BIT]) begin
          next_irq_flag = 1'b0;
        end
        if (unlock_open) begin
          next_reset_enable = reg_wdata[`WDG_RESET_EN_BIT];
          next_prescale = pre_field(reg_wdata);
        end else if (reg_wdata[`WDG_RESET_EN_BIT]) begin
          next_reset_enable = 1'b1;
        end
      end
      if (unlock_req) begin
        next_unlock = 1'b1;
        next_unlock_cnt = `WDG_UNLOCK_CYCLES;
      end else if (guard_change_unlock) begin
        if (unlock_cnt == 3'h1 || (wr_ctrl && unlock_open)) begin
          next_unlock = 1'b0;
          next_unlock_cnt = 3'h0;
        end else begin
          next_unlock_cnt = unlock_cnt - 3'h1;
        end
      end
      if (vec_ack && eff_reset_en) begin
        next_irq_enable = 1'b0;
        next_irq_flag = 1'b0;
      end else if (vec_ack) begin
        next_irq_flag = 1'b0;
      end
      if (irq_expire) begin
        next_irq_flag = 1'b1;
      end
      if (cause[`WDG_TIMEOUT_BIT]) begin
        next_reset_enable = 1'b1;
      end
    end
  end

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      guard_irq_flag <= 1'b0;
      guard_irq_enable <= 1'b0;
      guard_reset_enable <= 1'b0;
      guard_prescale_select <= 4'h0;
      guard_change_unlock <= 1'b0;
      unlock_cnt <= 3'h0;
      comparator_bandgap_select <= 1'b0;
    end else begin
      guard_irq_flag <= next_irq_flag;
      guard_irq_enable <= next_irq_enable;
      guard_reset_enable <= next_reset_enable;
      guard_prescale_select <= next_prescale;
      guard_change_unlock <= next_unlock;
      unlock_cnt <= next_unlock_cnt;
      comparator_bandgap_select <= next_bandgap_sel;
    end
  end

  // ----------------------------------------------------------------
  // outputs and read port
  // ----------------------------------------------------------------
  reg [7:0] next_rdata;

  // read data is zero outside the cycle after a read
  always @* begin
    next_rdata = 8'h00;
    if (reg_read) begin
      if (reg_addr == `WDG_ADDR_CAUSE) begin
        next_rdata = {4'h0, cause};
      end else if (reg_addr == `WDG_ADDR_CTRL) begin
        next_rdata = {guard_irq_flag, eff_irq_en, guard_prescale_select[3], guard_change_unlock,
          eff_reset_en, guard_prescale_select[2:0]};
      end else if (reg_addr == `WDG_ADDR_MISC) begin
        next_rdata = {7'h00, comparator_bandgap_select};
      end
    end
  end

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      reg_rdata <= 8'h00;
      guard_irq <= 1'b0;
      guard_system_reset <= 1'b0;
      bandgap_enable <= 1'b0;
    end else begin
      reg_rdata <= next_rdata;
      guard_irq <= guard_irq_flag & eff_irq_en;
      guard_system_reset <= rst_expire;
      bandgap_enable <= (low_supply_level_fuse != `WDG_LEVEL_OFF) | comparator_bandgap_select;
    end
  end
endmodule

// ==== shared/wdg_defs.vh ====
// register offsets, field positions and timing counts of the timeout guard
`ifndef WDG_DEFS_VH
`define WDG_DEFS_VH
// register map
`define WDG_ADDR_CAUSE 4'h0
`define WDG_ADDR_CTRL 4'h1
`define WDG_ADDR_MISC 4'h2
// reset cause fields
`define WDG_POWER_UP_BIT 0
`define WDG_PIN_BIT 1
`define WDG_LOW_SUPPLY_BIT 2
`define WDG_TIMEOUT_BIT 3
// control fields
`define WDG_PRE0_BIT 0
`define WDG_PRE1_BIT 1
`define WDG_PRE2_BIT 2
`define WDG_RESET_EN_BIT 3
`define WDG_UNLOCK_BIT 4
`define WDG_PRE3_BIT 5
`define WDG_IRQ_EN_BIT 6
`define WDG_IRQ_FLAG_BIT 7
// misc fields
`define WDG_BANDGAP_SEL_BIT 0
`define WDG_VECTOR_ACK_BIT 1
// reset values
`define WDG_CTRL_RESET 8'h00
`define WDG_LEVEL_OFF 3'h7
// timing
`define WDG_UNLOCK_CYCLES 3'h4
`define WDG_BASE_CYCLES 2048
`define WDG_MAX_CODE 4'h9
`define WDG_OSC_KHZ 128
`define WDG_CLK_KHZ 125000
`endif

// ==== hdl/wdg_tick_gen.v ====
// oscillator tick generator for the timeout guard
`timescale 1ns/1ns
module wdg_tick_gen #(
  parameter DIV = 976
) (
  // clock and reset
  input wire clk,
  input wire nrst,
  // tick out
  output reg tick
);
  reg [15:0] cnt;
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cnt <= 16'h0000;
      tick <= 1'b0;
    end else if (cnt >= DIV[15:0] - 16'h0001) begin
      cnt <= 16'h0000;
      tick <= 1'b1;
    end else begin
      cnt <= cnt + 16'h0001;
      tick <= 1'b0;
    end
  end
endmodule

// ==== testbench/wdg_guard_chk.sv ====
// port assertions of the timeout guard
`timescale 1ns/1ns
module wdg_guard_chk (
  // clock and reset
  input wire clk,
  input wire nrst,
  // watched inputs
  input wire guard_always_on_fuse,
  input wire [2:0] low_supply_level_fuse,
  input wire guard_restart,
  input wire guard_vector_taken,
  input wire [3:0] reg_addr,
  input wire reg_read,
  // watched outputs
  input wire [7:0] reg_rdata,
  input wire guard_irq,
  input wire guard_system_reset,
  input wire bandgap_enable
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  sequence s_fuse_held;
    guard_always_on_fuse [*3];
  endsequence
  sequence s_ctrl_read;
    reg_read && reg_addr == 4'h1;
  endsequence
  a_upper_zero: assert property (reg_read && reg_addr == 4'h0 |=> reg_rdata[7:4] == 4'h0)
    else $error("cause upper bits set");
  a_unmapped_zero: assert property (reg_read && reg_addr > 4'h2 |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_fuse_ctrl: assert property (s_fuse_held ##0 s_ctrl_read |=> reg_rdata[3] && !reg_rdata[6])
    else $error("fuse does not force reset mode");
  a_fuse_no_irq: assert property (s_fuse_held |=> !guard_irq)
    else $error("irq under fuse");
  a_bandgap_on: assert property ((low_supply_level_fuse != 3'h7) [*3] |=> bandgap_enable)
    else $error("bandgap off with detector on");
  a_restart_quiet: assert property (guard_restart |-> ##2 !guard_system_reset [*4])
    else $error("reset soon after restart");
  a_sysrst_spacing: assert property (guard_system_reset |=> !guard_system_reset [*6])
    else $error("system reset too close");
  a_vector_clears: assert property (guard_vector_taken |-> ##2 !guard_irq)
    else $error("irq kept after vector");
endmodule
bind wdg_guard wdg_guard_chk u_chk (.clk(clk), .nrst(nrst), .guard_always_on_fuse(guard_always_on_fuse),
  .low_supply_level_fuse(low_supply_level_fuse), .guard_restart(guard_restart),
  .guard_vector_taken(guard_vector_taken), .reg_addr(reg_addr), .reg_read(reg_read), .reg_rdata(reg_rdata),
  .guard_irq(guard_irq), .guard_system_reset(guard_system_reset), .bandgap_enable(bandgap_enable));

// ==== testbench/wdg_core_model.sv ====
// core model: register accesses, restarts, vector fetches
`timescale 1ns/1ns
module wdg_core_model (
  // clock
  input wire clk,
  // register port
  output logic [3:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic reg_write,
  output logic reg_read,
  input wire [7:0] reg_rdata,
  // core events
  output logic guard_restart,
  output logic guard_vector_taken
);
  initial {reg_addr, reg_wdata, reg_write, reg_read, guard_restart, guard_vector_taken} = 16'h0;
  task wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    {reg_addr, reg_wdata, reg_write} <= {a, d, 1'b1};
    @(posedge clk);
    {reg_wdata, reg_write} <= {~d, 1'b0};
  endtask
  task rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk);
    {reg_addr, reg_read} <= {a, 1'b1};
    @(posedge clk);
    reg_read <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task pulse(input logic vec);
    @(posedge clk);
    {guard_vector_taken, guard_restart} <= {vec, !vec};
    @(posedge clk);
    {guard_vector_taken, guard_restart} <= 2'b00;
  endtask
endmodule

// ==== testbench/testbench.sv ====
// self-checking bench of the timeout guard
`timescale 1ns/1ns
module testbench;
  logic clk, nrst, guard_always_on_fuse;
  logic [2:0] ev_in, low_supply_level_fuse;
  logic [7:0] rv;
  wire [3:0] reg_addr;
  wire [7:0] reg_wdata, reg_rdata;
  wire reg_write, reg_read, guard_restart, guard_vector_taken, guard_irq, guard_system_reset, bandgap_enable;
  int n_errors = 0;
  int num_checks = 0;
  int m_cause;
  int k;
  wdg_guard #(.OSC_DIV(2), .BASE_CYCLES(4)) dut (.clk(clk), .nrst(nrst), .power_up_reset(ev_in[2]),
    .pin_reset(ev_in[1]), .low_supply_reset(ev_in[0]), .guard_always_on_fuse(guard_always_on_fuse),
    .low_supply_level_fuse(low_supply_level_fuse), .guard_restart(guard_restart),
    .guard_vector_taken(guard_vector_taken), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
    .reg_read(reg_read), .reg_rdata(reg_rdata), .guard_irq(guard_irq), .guard_system_reset(guard_system_reset),
    .bandgap_enable(bandgap_enable));
  wdg_core_model core (.clk(clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
    .reg_read(reg_read), .reg_rdata(reg_rdata), .guard_restart(guard_restart),
    .guard_vector_taken(guard_vector_taken));
  task chk(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task close_out;
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task ev(input logic [2:0] m);
    @(posedge clk);
    ev_in <= m;
    @(posedge clk);
    ev_in <= 3'h0;
  endtask
  task rdc(input logic [3:0] a, input logic [7:0] exp);
    core.rd(a, rv);
    chk(rv, exp);
  endtask
  task wait_out(input logic irq, input int lo, input int hi);
    #1;
    for (k = 0; k < 200 && (irq ? guard_irq : guard_system_reset) !== 1'b1; k++) #8;
    chk({7'h0, k >= lo && k <= hi}, 8'h01);
  endtask
  task quiet;
    core.pulse(0);
    core.wr(4'h0, 8'h00);
    m_cause = 0;
    core.pulse(0);
    core.wr(4'h1, 8'h18);
    core.wr(4'h1, 8'h00);
  endtask
  initial begin
    clk = 0;
    forever #4 clk = ~clk;
  end
  initial begin
    #80000;
    n_errors++;
    close_out;
  end
  initial begin
    {nrst, ev_in, guard_always_on_fuse, low_supply_level_fuse} = 8'h07;
    rv = $urandom(32'h34d62582);
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    ev(3'h4);
    m_cause = 1;
    rdc(4'h0, m_cause[7:0]);
    repeat (4) begin
      rv = $urandom;
      ev(rv[2:0]);
      m_cause = rv[2] ? 1 : (m_cause | (rv[0] << 2) | (rv[1] << 1));
      rdc(4'h0, m_cause[7:0]);
    end
    ev(3'h4);
    m_cause = 1;
    rdc(4'h0, m_cause[7:0]);
    rv = $urandom;
    core.wr(4'h0, {rv[7:4], 4'h0});
    m_cause = 0;
    rdc(4'h0, 8'h00);
    rdc(4'h7, 8'h00);
    for (int lv = 0; lv < 16; lv++) begin
      low_supply_level_fuse <= lv[3:1];
      core.wr(4'h2, {7'h0, lv[0]});
      repeat (3) @(posedge clk);
      #1 chk({7'h0, bandgap_enable}, {7'h0, lv < 14 || lv[0]});
    end
    $display("cause and bandgap done");
    core.pulse(0);
    core.wr(4'h1, 8'h18);
    core.wr(4'h1, 8'h29);
    rdc(4'h1, 8'h29);
    core.wr(4'h1, 8'h39);
    rdc(4'h1, 8'h39);
    repeat (4) @(posedge clk);
    rdc(4'h1, 8'h29);
    core.wr(4'h1, 8'h00);
    rdc(4'h1, 8'h29);
    core.wr(4'h1, 8'h39);
    core.wr(4'h1, 8'h09);
    repeat (3) begin
      core.pulse(0);
      repeat (6) @(posedge clk);
    end
    core.pulse(0);
    wait_out(0, 12, 22);
    m_cause |= 8;
    core.pulse(0);
    rdc(4'h0, m_cause[7:0]);
    rdc(4'h1, 8'h09);
    core.pulse(0);
    core.wr(4'h1, 8'h18);
    core.wr(4'h1, 8'h01);
    rdc(4'h1, 8'h09);
    quiet;
    rdc(4'h1, 8'h00);
    rdc(4'h0, 8'h00);
    $display("unlock and reset mode done");
    core.wr(4'h1, 8'h40);
    wait_out(1, 4, 14);
    core.pulse(0);
    rdc(4'h1, 8'hC0);
    core.wr(4'h1, 8'h80);
    rdc(4'h1, 8'h00);
    core.pulse(0);
    core.wr(4'h1, 8'h48);
    wait_out(1, 4, 14);
    core.pulse(1);
    rdc(4'h1, 8'h08);
    wait_out(0, 0, 14);
    rdc(4'h0, 8'h08);
    quiet;
    $display("interrupt modes done");
    guard_always_on_fuse <= 1'b1;
    core.wr(4'h1, 8'h40);
    rdc(4'h1, 8'h08);
    wait_out(0, 0, 14);
    guard_always_on_fuse <= 1'b0;
    quiet;
    $display("fuse done");
    close_out;
  end
endmodule
